// [hdl/dac_pkg.sv]
/*
  Package for the dual converter control register block: register offsets,
  bit positions, reset values, start-mode codes and port carrier structs.
  Assumes an APB slave with 32-bit data and byte-addressed word registers.
*/
package dac_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses (printed offsets kept as indices, times four)
  // ----------------------------------------------------------------------
  localparam logic [7:0]  IDX_CTRL0  = 8'h8e;
  localparam logic [7:0]  IDX_CTRL1  = 8'h97;
  localparam logic [7:0]  IDX_MODE_B = 8'ha1;
  localparam logic [7:0]  IDX_MODE_A = 8'hc0;
  localparam logic [11:0] ADDR_CTRL0  = {2'h0, IDX_CTRL0, 2'h0};
  localparam logic [11:0] ADDR_CTRL1  = {2'h0, IDX_CTRL1, 2'h0};
  localparam logic [11:0] ADDR_MODE_B = {2'h0, IDX_MODE_B, 2'h0};
  localparam logic [11:0] ADDR_MODE_A = {2'h0, IDX_MODE_A, 2'h0};

  // ----------------------------------------------------------------------
  // Control register fields (same positions for both converters)
  // ----------------------------------------------------------------------
  localparam int CTL_START_LO   = 0;
  localparam int CTL_ENABLE     = 2;
  localparam int CTL_DONE       = 3;
  localparam int CTL_EDGE_POL   = 4;
  localparam int CTL_TIMER_TRIG = 5;
  localparam int CTL_DONE_IE    = 6;
  localparam int CTL_LIMIT_IE   = 7;

  // ----------------------------------------------------------------------
  // Mode register A fields: base positions, second converter adds 4
  // ----------------------------------------------------------------------
  localparam int MDA_SINGLE  = 0;
  localparam int MDA_FIXED   = 1;
  localparam int MDA_SCAN    = 2;
  localparam int MDA_LIMIT   = 3;
  localparam int MDA_STRIDE  = 4;

  // ----------------------------------------------------------------------
  // Mode register B fields
  // ----------------------------------------------------------------------
  localparam int MDB_ALL_LIMIT0 = 0;
  localparam int MDB_ALL_LIMIT1 = 1;
  localparam int MDB_DAC0       = 2;
  localparam int MDB_DAC1       = 3;
  localparam int MDB_DIV_LO     = 5;

  localparam logic [7:0] RST_CTRL0  = 8'h00;
  localparam logic [7:0] RST_CTRL1  = 8'h00;
  localparam logic [7:0] RST_MODE_A = 8'h00;
  localparam logic [7:0] RST_MODE_B = 8'h00;
  localparam logic [7:0] MDB_WMASK  = 8'hef;

  typedef enum logic [1:0] {
    DAC_START_TIMER_OR_STOP = 2'h0,
    DAC_START_IMMEDIATE     = 2'h1,
    DAC_START_EDGE          = 2'h2,
    DAC_START_DUAL          = 2'h3
  } dac_start_e;

  // Converter core status, one set per converter.
  typedef struct packed {
    logic done;
    logic out_of_range;
    logic first_input;
  } dac_core_evt_s;

  // Converter core controls, one set per converter.
  typedef struct packed {
    logic       start;
    logic       enable;
    logic       dac_mode;
    logic       single_mode;
    logic       fixed_cont;
    logic       scan_cont;
    logic       single_step;
  } dac_core_ctl_s;

endpackage : dac_pkg

// [hdl/dac_regs.sv]
/*
  Dual converter control and mode registers behind an APB slave. Produces
  start pulses, mode levels, a divided converter clock enable and the two
  interrupt requests. Assumes the converter cores report done and
  out-of-range as one-cycle pulses on pclk, timer overflow is a pclk pulse,
  and the trigger pin is asynchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Code 00 with timer bit starts on overflow.
// - Code 00 without timer bit is stop.
// - Writing code 01 starts immediately.
// - Code 10 starts on selected pin edge.
// - Writing code 11 starts both converters together.
// - Bit 2 enables converter and DAC output.
// - Done flag set by hardware, cleared by software.
// - Edge bit 0 falling, 1 rising.
// - Done flag with enable requests interrupt.
// - Limit flag with enable requests interrupt.
// - Single-conversion mode bits 0 and 4.
// - Fixed continuous mode bits 1 and 5.
// - Scan continuous mode bits 2 and 6.
// - Limit flag set when result out of range.
// - Second control register mirrors first layout.
// - Mode B: divider, DAC selects, all-limit, reserved.
// - Converter clock is pclk over divider plus one.
// - Triggers ignored while conversion is running.
// - All mode bits clear means single step.
// - All-limit bit picks any input or first.
module dac_regs #(
  parameter int ADDR_W = 12
) (
  input  wire  logic                 pclk,
  input  wire  logic                 presetn,
  input  wire  logic                 psel,
  input  wire  logic                 penable,
  input  wire  logic                 pwrite,
  input  wire  logic [ADDR_W-1:0]    paddr,
  input  wire  logic [31:0]          pwdata,
  input  wire  logic [3:0]           pstrb,
  output logic                       pready,
  output logic                       pslverr,
  output logic [31:0]                prdata,
  input  wire  logic                 timer0_overflow,
  input  wire  logic                 edge_trigger_pin,
  input  wire  logic                 conv_irq_global_en,
  input  wire  dac_pkg::dac_core_evt_s core_evt0,
  input  wire  dac_pkg::dac_core_evt_s core_evt1,
  output dac_pkg::dac_core_ctl_s     core_ctl0,
  output dac_pkg::dac_core_ctl_s     core_ctl1,
  output logic                       conv_clk_en,
  output logic                       conv0_irq,
  output logic                       conv1_irq
);
  import dac_pkg::*;

  initial begin
    if (ADDR_W < 12) begin
      $error("dac_regs: ADDR_W must be at least 12");
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [7:0]  mode_a;
    logic [7:0]  mode_b;
    logic [1:0]  busy;
    logic [2:0]  pin_sync;
    logic [2:0]  div_cnt;
    logic [1:0]  start;
    logic        clk_en;
    logic [31:0] rdata;
  } dac_state_s;

  dac_state_s state_reg;
  dac_state_s state_next;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] dac_reg_read(input dac_state_s s,
                                              input logic [11:0] a);
    unique case (a)
      ADDR_CTRL0:  dac_reg_read = s.ctrl0;
      ADDR_CTRL1:  dac_reg_read = s.ctrl1;
      ADDR_MODE_A: dac_reg_read = s.mode_a;
      ADDR_MODE_B: dac_reg_read = s.mode_b & MDB_WMASK;
      default:     dac_reg_read = 8'h00;
    endcase
  endfunction : dac_reg_read

  // Trigger for one converter from its control byte and the shared events.
  function automatic logic dac_trigger(input logic [7:0] c,
                                       input logic       tmr,
                                       input logic       rise,
                                       input logic       fall);
    logic [1:0] code;
    code = c[CTL_START_LO +: 2];
    unique case (code)
      DAC_START_TIMER_OR_STOP: dac_trigger = c[CTL_TIMER_TRIG] & tmr;
      DAC_START_EDGE: dac_trigger = c[CTL_EDGE_POL] ? rise : fall;
      default:        dac_trigger = 1'b0;
    endcase
  endfunction : dac_trigger

  logic [11:0] addr12;
  logic        ack_reg;
  logic        wr_acc;
  logic        rd_acc;
  logic        mapped;
  logic        pin_rise;
  logic        pin_fall;
  logic [2:0]  div_sel;
  logic [7:0]  wbyte;
  logic        imm0;
  logic        imm1;
  logic        dual;
  logic        trig0;
  logic        trig1;
  logic        lim0;
  logic        lim1;

  assign addr12 = paddr[11:0];
  assign mapped = (addr12 == ADDR_CTRL0) || (addr12 == ADDR_CTRL1) ||
                  (addr12 == ADDR_MODE_A) || (addr12 == ADDR_MODE_B);
  // A write lands only at the edge that ends the transfer, so an immediate
  // start code is seen once and gives a single start pulse.
  assign wr_acc = psel & penable & pwrite & pstrb[0] & ack_reg;
  // Read data is captured one cycle early so it stands from a flip-flop
  // exactly in the cycle in which pready is high, and nowhere else.
  assign rd_acc = psel & penable & ~pwrite & ~ack_reg;
  assign wbyte  = pwdata[7:0];

  assign pin_rise = state_reg.pin_sync[1] & ~state_reg.pin_sync[2];
  assign pin_fall = ~state_reg.pin_sync[1] & state_reg.pin_sync[2];
  assign div_sel  = state_reg.mode_b[MDB_DIV_LO +: 3];

  // Immediate starts come from the written code, not the stored one.
  assign imm0 = wr_acc && addr12 == ADDR_CTRL0 &&
                wbyte[CTL_START_LO +: 2] == DAC_START_IMMEDIATE;
  assign imm1 = wr_acc && addr12 == ADDR_CTRL1 &&
                wbyte[CTL_START_LO +: 2] == DAC_START_IMMEDIATE;
  assign dual = wr_acc && (addr12 == ADDR_CTRL0 || addr12 == ADDR_CTRL1) &&
                wbyte[CTL_START_LO +: 2] == DAC_START_DUAL;

  assign trig0 = dac_trigger(state_reg.ctrl0, timer0_overflow,
                             pin_rise, pin_fall);
  assign trig1 = dac_trigger(state_reg.ctrl1, timer0_overflow,
                             pin_rise, pin_fall);

  // With all-limit clear only a result from the first input counts.
  assign lim0 = core_evt0.out_of_range & (state_reg.mode_b[MDB_ALL_LIMIT0] |
                core_evt0.first_input);
  assign lim1 = core_evt1.out_of_range & (state_reg.mode_b[MDB_ALL_LIMIT1] |
                core_evt1.first_input);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.pin_sync = {state_reg.pin_sync[1:0], edge_trigger_pin};

    // Divider: one enable pulse every div_sel+1 cycles.
    if (state_reg.div_cnt >= div_sel) begin
      state_next.div_cnt = 3'h0;
      state_next.clk_en  = 1'b1;
    end else begin
      state_next.div_cnt = state_reg.div_cnt + 3'h1;
      state_next.clk_en  = 1'b0;
    end

    if (wr_acc) begin
      unique case (addr12)
        ADDR_CTRL0:  state_next.ctrl0 = wbyte;
        ADDR_CTRL1:  state_next.ctrl1 = wbyte;
        ADDR_MODE_A: state_next.mode_a = wbyte;
        ADDR_MODE_B: state_next.mode_b = wbyte & MDB_WMASK;
        default: begin
        end
      endcase
    end

    // Hardware sets land after software writes so they win.
    if (core_evt0.done) begin
      state_next.ctrl0[CTL_DONE] = 1'b1;
    end
    if (core_evt1.done) begin
      state_next.ctrl1[CTL_DONE] = 1'b1;
    end
    if (lim0) begin
      state_next.mode_a[MDA_LIMIT] = 1'b1;
    end
    if (lim1) begin
      state_next.mode_a[MDA_LIMIT + MDA_STRIDE] = 1'b1;
    end

    // A converter disabled before the edge never starts; a busy one ignores triggers.
    state_next.start[0] = state_reg.ctrl0[CTL_ENABLE] &
                          (imm0 | dual | (trig0 & ~state_reg.busy[0]));
    state_next.start[1] = state_reg.ctrl1[CTL_ENABLE] &
                          (imm1 | dual | (trig1 & ~state_reg.busy[1]));
    if (state_next.start[0]) begin
      state_next.busy[0] = 1'b1;
    end else if (core_evt0.done || !state_reg.ctrl0[CTL_ENABLE]) begin
      state_next.busy[0] = 1'b0;
    end
    if (state_next.start[1]) begin
      state_next.busy[1] = 1'b1;
    end else if (core_evt1.done || !state_reg.ctrl1[CTL_ENABLE]) begin
      state_next.busy[1] = 1'b0;
    end

    state_next.rdata = rd_acc ? {24'h0, dac_reg_read(state_reg, addr12)}
                              : 32'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg          <= '0;
      state_reg.ctrl0    <= RST_CTRL0;
      state_reg.ctrl1    <= RST_CTRL1;
      state_reg.mode_a   <= RST_MODE_A;
      state_reg.mode_b   <= RST_MODE_B;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // One wait state lets read data come straight from a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= psel & penable & ~ack_reg;
    end
  end

  // Writes and the slave error happen only in the completing cycle.
  assign pready  = ack_reg;
  assign pslverr = ack_reg & ~mapped;
  assign prdata  = state_reg.rdata;
  assign conv_clk_en = state_reg.clk_en;

  always_comb begin
    core_ctl0.start       = state_reg.start[0];
    core_ctl0.enable      = state_reg.ctrl0[CTL_ENABLE];
    core_ctl0.dac_mode    = state_reg.ctrl0[CTL_ENABLE] &
                            state_reg.mode_b[MDB_DAC0];
    core_ctl0.single_mode = state_reg.mode_a[MDA_SINGLE];
    core_ctl0.fixed_cont  = state_reg.mode_a[MDA_FIXED];
    core_ctl0.scan_cont   = state_reg.mode_a[MDA_SCAN];
    core_ctl0.single_step = state_reg.mode_a[2:0] == 3'h0;
    core_ctl1.start       = state_reg.start[1];
    core_ctl1.enable      = state_reg.ctrl1[CTL_ENABLE];
    core_ctl1.dac_mode    = state_reg.ctrl1[CTL_ENABLE] &
                            state_reg.mode_b[MDB_DAC1];
    core_ctl1.single_mode = state_reg.mode_a[MDA_SINGLE + MDA_STRIDE];
    core_ctl1.fixed_cont  = state_reg.mode_a[MDA_FIXED + MDA_STRIDE];
    core_ctl1.scan_cont   = state_reg.mode_a[MDA_SCAN + MDA_STRIDE];
    core_ctl1.single_step = state_reg.mode_a[6:4] == 3'h0;
  end

  assign conv0_irq = conv_irq_global_en &
    ((state_reg.ctrl0[CTL_DONE_IE] & state_reg.ctrl0[CTL_DONE]) |
     (state_reg.ctrl0[CTL_LIMIT_IE] & state_reg.mode_a[MDA_LIMIT]));
  assign conv1_irq = conv_irq_global_en &
    ((state_reg.ctrl1[CTL_DONE_IE] & state_reg.ctrl1[CTL_DONE]) |
     (state_reg.ctrl1[CTL_LIMIT_IE] &
      state_reg.mode_a[MDA_LIMIT + MDA_STRIDE]));

endmodule : dac_regs

`default_nettype wire

// [sim/dac_core_model.sv]
/*
  Behavioural model of one converter core on the far side of the block.
  Assumes start is a pclk pulse; answers done after lat cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_core_model
  import dac_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [7:0]    lat,
  input  wire logic          oor,
  input  wire logic          first,
  input  wire dac_core_ctl_s ctl,
  output dac_core_evt_s      evt
);
  logic [7:0] cnt_reg;
  // A new start restarts the count, as a real core would abort and retake.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
      evt     <= '0;
    end else begin
      evt.done         <= !ctl.start && cnt_reg == 8'h01;
      evt.out_of_range <= !ctl.start && cnt_reg == 8'h01 && oor;
      evt.first_input  <= first;
      if (ctl.start)
        cnt_reg <= lat;
      else if (cnt_reg != 8'h00)
        cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule : dac_core_model
`default_nettype wire

// [sim/dac_regs_asserts.sv]
/*
  Concurrent checks on the ports of the converter register block.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_regs_chk
  import dac_pkg::*;
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [31:0]   prdata,
  input wire logic          conv_irq_global_en,
  input wire dac_core_evt_s core_evt0,
  input wire dac_core_ctl_s core_ctl0,
  input wire dac_core_ctl_s core_ctl1,
  input wire logic          conv0_irq,
  input wire logic          conv1_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------------
  // Busy tracking
  // ----------------------------------------------------------------------
  logic busy_reg;
  logic busy_next;
  always_comb busy_next = !core_evt0.done && (core_ctl0.start || busy_reg);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      busy_reg <= 1'b0;
    else
      busy_reg <= busy_next;
  end
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_PREADY_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not one cycle after penable");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  AST_RDATA_BYTE: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("prdata upper bits set");
  AST_IRQ_GLOBAL: assert property (!conv_irq_global_en |-> !(conv0_irq || conv1_irq))
    else $error("irq without global enable");
  AST_START_EN: assert property (core_ctl0.start |-> core_ctl0.enable)
    else $error("start while disabled");
  AST_DAC_EN: assert property (core_ctl0.dac_mode |-> core_ctl0.enable)
    else $error("dac mode while disabled");
  AST_NO_RETRIG: assert property (busy_reg && !$past(psel && penable && pwrite) |-> !core_ctl0.start)
    else $error("trigger taken while busy");
  AST_STEP: assert property (core_ctl1.single_step == !(core_ctl1.single_mode || core_ctl1.fixed_cont || core_ctl1.scan_cont))
    else $error("single step mismatch");
  cover property (core_ctl0.start && core_ctl1.start);
  cover property (pslverr);
  cover property (conv0_irq);
  cover property (core_evt0.out_of_range);
endmodule : dac_regs_chk
bind dac_regs dac_regs_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .conv_irq_global_en(conv_irq_global_en),
  .core_evt0(core_evt0), .core_ctl0(core_ctl0), .core_ctl1(core_ctl1),
  .conv0_irq(conv0_irq), .conv1_irq(conv1_irq));
`default_nettype wire

// [sim/tb.sv]
/*
  Self-checking bench: APB tasks, two core models, register scenarios.
  Assumes the package, the register block and the models compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dac_pkg::*;
  logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]   paddr = '0;
  logic [31:0]   pwdata = '0, prdata, rd;
  logic          pready, pslverr, err, clk_en, irq0, irq1;
  logic          tmr = 0, pin = 0, glob = 0, oor = 0, first = 0;
  logic [7:0]    lat = 8'h06;
  dac_core_evt_s evt0, evt1;
  dac_core_ctl_s ctl0, ctl1;
  int            n_mismatch = 0, check_count = 0, ns0 = 0, ns1 = 0, cyc = 0;
  int            k0, k1;
  logic [11:0]   ad [4] = '{ADDR_CTRL0, ADDR_CTRL1, ADDR_MODE_B, ADDR_MODE_A};
  logic [15:0]   tbl [4] = '{16'h4242, 16'h2184, 16'h1428, 16'h0011};
  always #5 pclk = ~pclk;
  dac_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .timer0_overflow(tmr), .edge_trigger_pin(pin),
    .conv_irq_global_en(glob), .core_evt0(evt0), .core_evt1(evt1),
    .core_ctl0(ctl0), .core_ctl1(ctl1), .conv_clk_en(clk_en),
    .conv0_irq(irq0), .conv1_irq(irq1));
  dac_core_model core0_u (.pclk(pclk), .presetn(presetn), .lat(lat),
    .oor(oor), .first(first), .ctl(ctl0), .evt(evt0));
  dac_core_model core1_u (.pclk(pclk), .presetn(presetn), .lat(lat),
    .oor(oor), .first(first), .ctl(ctl1), .evt(evt1));
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Ready and read data are taken at the rising edge that ends the access.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask : rdchk
  task automatic tp(input int n);
    @(posedge pclk);
    tmr <= 1'b1;
    @(posedge pclk);
    tmr <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask : tp
  always @(posedge pclk) begin
    ns0 += int'(ctl0.start === 1'b1);
    ns1 += int'(ctl1.start === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ad[i]) rdchk(ad[i], 32'h0);
    apb(12'h004, 1'b0, 32'h0);
    chk(err, 1'b1);
    wr(ADDR_MODE_B, 32'hff);
    rdchk(ADDR_MODE_B, 32'hef);
    for (int d = 2; d < 8; d += 5) begin
      wr(ADDR_MODE_B, {24'h0, d[2:0], 5'h0});
      repeat (2) @(posedge pclk iff clk_en === 1'b1);
      k0 = 0;
      do begin
        @(posedge pclk);
        k0++;
      end while (clk_en !== 1'b1);
      chk(k0, d + 1);
    end
    foreach (tbl[i]) begin
      wr(ADDR_MODE_A, {24'h0, tbl[i][15:8]});
      rdchk(ADDR_MODE_A, {24'h0, tbl[i][15:8]});
      chk({ctl0[3:0], ctl1[3:0]}, tbl[i][7:0]);
    end
    lat <= 8'h14;
    wr(ADDR_CTRL0, 32'h24);
    k0 = ns0;
    tp(5);
    tp(40);
    chk(ns0 - k0, 1);
    tp(30);
    chk(ns0 - k0, 2);
    rdchk(ADDR_CTRL0, 32'h2c);
    wr(ADDR_CTRL0, 32'h04);
    rdchk(ADDR_CTRL0, 32'h04);
    tp(30);
    chk(ns0 - k0, 2);
    lat <= 8'h06;
    wr(ADDR_CTRL0, 32'h05);
    repeat (20) @(posedge pclk);
    chk(ns0 > k0 + 2, 1'b1);
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_CTRL1, {27'h0, p[0], 4'h6});
      for (int v = 1; v >= 0; v--) begin
        k1 = ns1;
        @(posedge pclk);
        pin <= v[0];
        repeat (30) @(posedge pclk);
        chk(ns1 - k1, v == p);
      end
    end
    k0 = ns0;
    k1 = ns1;
    wr(ADDR_CTRL0, 32'h07);
    repeat (20) @(posedge pclk);
    chk({ns0 > k0, ns1 > k1}, 2'b11);
    glob <= 1'b1;
    wr(ADDR_CTRL0, 32'h44);
    @(negedge pclk);
    chk(irq0, 1'b0);
    wr(ADDR_CTRL0, 32'h45);
    repeat (20) @(posedge pclk);
    chk(irq0, 1'b1);
    glob <= 1'b0;
    @(negedge pclk);
    chk(irq0, 1'b0);
    glob <= 1'b1;
    oor <= 1'b1;
    wr(ADDR_CTRL0, 32'h85);
    repeat (20) @(posedge pclk);
    rdchk(ADDR_MODE_A, 32'h00);
    chk(irq0, 1'b0);
    wr(ADDR_MODE_B, 32'h05);
    wr(ADDR_CTRL0, 32'h85);
    repeat (20) @(posedge pclk);
    rdchk(ADDR_MODE_A, 32'h08);
    chk({irq0, ctl0.dac_mode}, 2'b11);
    chk(irq1, 1'b0);
    final_report();
  end
endmodule : tb
`default_nettype wire
